// ---- pdcr_pkg.sv ----
package pdcr_pkg;

    // ==========================================================
    // Register indexes
    localparam logic [2:0] REF_PREDIV_IDX = 3'h0;
    localparam logic [2:0] FB_MOD_IDX = 3'h1;
    localparam logic [2:0] FB_INT_IDX = 3'h2;
    localparam logic [2:0] FB_FRAC_IDX = 3'h3;
    localparam logic [2:0] OSC_BIAS_IDX = 3'h4;
    localparam logic [2:0] SYS_DIV_IDX = 3'h5;
    localparam int REG_COUNT = 6;

    // ==========================================================
    // Field positions
    localparam int MOD_EN_BIT = 7;
    localparam int MOD_ORDER_MSB = 1;
    localparam int PREDIV_MSB = 2;
    localparam int BIAS_MSB = 4;
    localparam int SYS_DIV_MSB = 4;
    localparam int FB_INT_MSB = 7;
    localparam int FB_FRAC_MSB = 15;

    // ==========================================================
    // Reset values
    localparam logic [2:0] PREDIV_RESET = 3'h1;
    localparam logic MOD_EN_RESET = 1'h1;
    localparam logic [1:0] MOD_ORDER_RESET = 2'h1;
    localparam logic [7:0] FB_INT_RESET = 8'h23;
    localparam logic [15:0] FB_FRAC_RESET = 16'h2800;
    localparam logic [4:0] BIAS_RESET = 5'h04;
    localparam logic [4:0] SYS_DIV_RESET = 5'h0C;

    // ==========================================================
    // Encodings
    localparam logic [1:0] ORDER_INTEGER = 2'h0;
    localparam logic [1:0] SYS_PRE_SHIFT = 2'h2;

    typedef struct packed {
        logic [2:0] prediv;
        logic modEnable;
        logic [1:0] modOrder;
        logic [7:0] fbInt;
        logic [15:0] fbFrac;
        logic [4:0] biasSet;
        logic [4:0] sysDiv;
        logic [15:0] rdData;
        logic rdValid;
        logic [5:0] convInput;
        logic [15:0] fbFracEff;
        logic [1:0] modOrderEff;
        logic [6:0] sysDivTotal;
    } pdcr_state_type;

endpackage

// ---- pdcr_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module pdcr_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [2:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    output logic regRdValid,
    // Dynamic converter control from modulator
    input wire logic [4:0] dacDynamic,
    // Divider chain controls
    output logic [2:0] refPredivCode,
    output logic feedbackModulatorEnable,
    output logic [1:0] feedbackModulatorOrder,
    output logic [7:0] feedbackDivideInteger,
    output logic [15:0] feedbackDivideFraction,
    output logic [5:0] converterInput,
    output logic [4:0] sysDivInteger,
    output logic [6:0] sysDivTotal
);

    pdcr_pkg::pdcr_state_type stateReg;
    pdcr_pkg::pdcr_state_type stateNext;
    logic [pdcr_pkg::REG_COUNT-1:0] wrSel;
    logic [pdcr_pkg::REG_COUNT-1:0] rdSel;

    // ==========================================================
    // Address decode
    function automatic logic addrHit(input logic [2:0] a, input int idx);
        return a == 3'(idx);
    endfunction

    // One write and one read select per mapped register
    for (genvar i = 0; i < pdcr_pkg::REG_COUNT; i++) begin : g_reg_sel
        assign wrSel[i] = regWrEn && addrHit(regAddr, i);
        assign rdSel[i] = regRdEn && addrHit(regAddr, i);
    end

    // ==========================================================
    // Register images, reserved bits read zero
    function automatic logic [15:0] predivImage(input pdcr_pkg::pdcr_state_type s);
        logic [15:0] d;
        d = 16'h0000;
        d[pdcr_pkg::PREDIV_MSB:0] = s.prediv;
        return d;
    endfunction

    function automatic logic [15:0] modImage(input pdcr_pkg::pdcr_state_type s);
        logic [15:0] d;
        d = 16'h0000;
        d[pdcr_pkg::MOD_EN_BIT] = s.modEnable;
        d[pdcr_pkg::MOD_ORDER_MSB:0] = s.modOrder;
        return d;
    endfunction

    function automatic logic [15:0] intImage(input pdcr_pkg::pdcr_state_type s);
        logic [15:0] d;
        d = 16'h0000;
        d[pdcr_pkg::FB_INT_MSB:0] = s.fbInt;
        return d;
    endfunction

    function automatic logic [15:0] fracImage(input pdcr_pkg::pdcr_state_type s);
        logic [15:0] d;
        d = 16'h0000;
        d[pdcr_pkg::FB_FRAC_MSB:0] = s.fbFrac;
        return d;
    endfunction

    function automatic logic [15:0] biasImage(input pdcr_pkg::pdcr_state_type s);
        logic [15:0] d;
        d = 16'h0000;
        d[pdcr_pkg::BIAS_MSB:0] = s.biasSet;
        return d;
    endfunction

    function automatic logic [15:0] sysDivImage(input pdcr_pkg::pdcr_state_type s);
        logic [15:0] d;
        d = 16'h0000;
        d[pdcr_pkg::SYS_DIV_MSB:0] = s.sysDiv;
        return d;
    endfunction

    // ==========================================================
    // Read mux, zero for unmapped indexes
    function automatic logic [15:0] readMux(input logic [pdcr_pkg::REG_COUNT-1:0] sel,
                                            input pdcr_pkg::pdcr_state_type s);
        logic [15:0] d;
        d = 16'h0000;
        if (sel[pdcr_pkg::REF_PREDIV_IDX]) begin
            d = d | predivImage(s);
        end
        if (sel[pdcr_pkg::FB_MOD_IDX]) begin
            d = d | modImage(s);
        end
        if (sel[pdcr_pkg::FB_INT_IDX]) begin
            d = d | intImage(s);
        end
        if (sel[pdcr_pkg::FB_FRAC_IDX]) begin
            d = d | fracImage(s);
        end
        if (sel[pdcr_pkg::OSC_BIAS_IDX]) begin
            d = d | biasImage(s);
        end
        if (sel[pdcr_pkg::SYS_DIV_IDX]) begin
            d = d | sysDivImage(s);
        end
        return d;
    endfunction

    // ==========================================================
    // Derived controls
    function automatic logic [15:0] effFraction(input pdcr_pkg::pdcr_state_type s);
        logic [15:0] f;
        f = 16'h0000;
        // Disabled modulator: integer-only division
        if (s.modEnable) begin
            f = s.fbFrac;
        end
        return f;
    endfunction

    function automatic logic [1:0] effOrder(input pdcr_pkg::pdcr_state_type s);
        logic [1:0] o;
        o = pdcr_pkg::ORDER_INTEGER;
        // Reserved order code passes through as stored
        if (s.modEnable) begin
            o = s.modOrder;
        end
        return o;
    endfunction

    function automatic logic [5:0] convSum(input logic [4:0] bias, input logic [4:0] dyn);
        logic [5:0] sum;
        sum = 6'({1'b0, bias} + {1'b0, dyn});
        return sum;
    endfunction

    function automatic logic [6:0] sysTotal(input logic [4:0] div);
        logic [6:0] t;
        t = 7'({2'b00, div} << pdcr_pkg::SYS_PRE_SHIFT);
        return t;
    endfunction

    // ==========================================================
    // Power-on contents
    function automatic pdcr_pkg::pdcr_state_type resetState();
        pdcr_pkg::pdcr_state_type s;
        // Derived fields stay zero until the first edge after rst is released
        s = '0;
        s.prediv = pdcr_pkg::PREDIV_RESET;
        s.modEnable = pdcr_pkg::MOD_EN_RESET;
        s.modOrder = pdcr_pkg::MOD_ORDER_RESET;
        s.fbInt = pdcr_pkg::FB_INT_RESET;
        s.fbFrac = pdcr_pkg::FB_FRAC_RESET;
        s.biasSet = pdcr_pkg::BIAS_RESET;
        s.sysDiv = pdcr_pkg::SYS_DIV_RESET;
        return s;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        stateNext = stateReg;
        // Read shows contents from before a same-cycle write
        stateNext.rdValid = regRdEn;
        stateNext.rdData = readMux(rdSel, stateReg);
        // Register writes
        if (wrSel[pdcr_pkg::REF_PREDIV_IDX]) begin
            stateNext.prediv = regWrData[pdcr_pkg::PREDIV_MSB:0];
        end
        if (wrSel[pdcr_pkg::FB_MOD_IDX]) begin
            stateNext.modEnable = regWrData[pdcr_pkg::MOD_EN_BIT];
            stateNext.modOrder = regWrData[pdcr_pkg::MOD_ORDER_MSB:0];
        end
        if (wrSel[pdcr_pkg::FB_INT_IDX]) begin
            stateNext.fbInt = regWrData[pdcr_pkg::FB_INT_MSB:0];
        end
        if (wrSel[pdcr_pkg::FB_FRAC_IDX]) begin
            stateNext.fbFrac = regWrData[pdcr_pkg::FB_FRAC_MSB:0];
        end
        if (wrSel[pdcr_pkg::OSC_BIAS_IDX]) begin
            stateNext.biasSet = regWrData[pdcr_pkg::BIAS_MSB:0];
        end
        if (wrSel[pdcr_pkg::SYS_DIV_IDX]) begin
            stateNext.sysDiv = regWrData[pdcr_pkg::SYS_DIV_MSB:0];
        end
        // Derived controls lag stored fields by one cycle
        stateNext.fbFracEff = effFraction(stateReg);
        stateNext.modOrderEff = effOrder(stateReg);
        stateNext.convInput = convSum(stateReg.biasSet, dacDynamic);
        stateNext.sysDivTotal = sysTotal(stateReg.sysDiv);
        if (rst) begin
            stateNext = resetState();
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk) begin
        stateReg <= stateNext;
    end

    // ==========================================================
    // Outputs
    assign regRdData = stateReg.rdData;
    assign regRdValid = stateReg.rdValid;
    assign refPredivCode = stateReg.prediv;
    assign feedbackModulatorEnable = stateReg.modEnable;
    assign feedbackModulatorOrder = stateReg.modOrderEff;
    assign feedbackDivideInteger = stateReg.fbInt;
    assign feedbackDivideFraction = stateReg.fbFracEff;
    assign converterInput = stateReg.convInput;
    assign sysDivInteger = stateReg.sysDiv;
    assign sysDivTotal = stateReg.sysDivTotal;

endmodule // pdcr_regs
`default_nettype wire

// ---- pdcr_regs_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module pdcr_regs_checker (
    // Register port
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    input wire logic regRdValid,
    input wire logic [4:0] dacDynamic,
    // Divider controls
    input wire logic feedbackModulatorEnable,
    input wire logic [1:0] feedbackModulatorOrder,
    input wire logic [7:0] feedbackDivideInteger,
    input wire logic [15:0] feedbackDivideFraction,
    input wire logic [5:0] converterInput,
    input wire logic [4:0] sysDivInteger,
    input wire logic [6:0] sysDivTotal
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_sys_wr;
        regWrEn && regAddr == 3'h5;
    endsequence
    a_sys_write: assert property (s_sys_wr |=> sysDivInteger == $past(regWrData[4:0]) ##1
        sysDivTotal == {$past(regWrData[4:0], 2), 2'h0}) else $error("sys div");
    a_int_write: assert property (regWrEn && regAddr == 3'h2 |=>
        feedbackDivideInteger == $past(regWrData[7:0])) else $error("integer");
    a_enable_write: assert property (regWrEn && regAddr == 3'h1 |=>
        feedbackModulatorEnable == $past(regWrData[7])) else $error("enable");
    a_frac_gated: assert property ($past(feedbackModulatorEnable) == 1'h0 |->
        feedbackDivideFraction == 16'h0000) else $error("fraction");
    a_order_gated: assert property ($past(feedbackModulatorEnable) == 1'h0 |->
        feedbackModulatorOrder == 2'h0) else $error("order");
    a_conv_follow: assert property (!$past(rst) && !$past(rst, 2) && !$past(regWrEn, 2) |->
        converterInput == $past(converterInput) + $past(dacDynamic) - $past(dacDynamic, 2))
        else $error("converter");
    a_unmapped_zero: assert property (regRdEn && regAddr[2:1] == 2'h3 |=>
        regRdValid && regRdData == 16'h0000) else $error("unmapped");
    a_read_valid: assert property (regRdEn |=> regRdValid ##1 !regRdValid || $past(regRdEn))
        else $error("valid");
endmodule // pdcr_regs_checker
bind pdcr_regs pdcr_regs_checker u_pdcr_regs_checker (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .dacDynamic(dacDynamic),
    .feedbackModulatorEnable(feedbackModulatorEnable),
    .feedbackModulatorOrder(feedbackModulatorOrder),
    .feedbackDivideInteger(feedbackDivideInteger),
    .feedbackDivideFraction(feedbackDivideFraction),
    .converterInput(converterInput), .sysDivInteger(sysDivInteger),
    .sysDivTotal(sysDivTotal)
);
`default_nettype wire

// ---- pdcr_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module pdcr_regs_tb_top;
    logic ref_clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, regRdValid;
    logic feedbackModulatorEnable;
    logic [2:0] regAddr = 3'h0, refPredivCode;
    logic [15:0] regWrData = 16'h0000, regRdData, feedbackDivideFraction, d, expQ[$];
    logic [4:0] dacDynamic = 5'h00, sysDivInteger;
    logic [1:0] feedbackModulatorOrder;
    logic [7:0] feedbackDivideInteger;
    logic [5:0] converterInput;
    logic [6:0] sysDivTotal;
    logic [15:0] mask[8] = '{16'h7, 16'h83, 16'hFF, 16'hFFFF, 16'h1F, 16'h1F, 16'h0, 16'h0};
    logic [15:0] rstVal[8] = '{16'h1, 16'h81, 16'h23, 16'h2800, 16'h4, 16'hC, 16'h0, 16'h0};
    int miscompares = 0, cmp_count = 0;
    always #5 ref_clk = ~ref_clk;
    pdcr_regs u_pdcr_regs (
        .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .dacDynamic(dacDynamic), .refPredivCode(refPredivCode),
        .feedbackModulatorEnable(feedbackModulatorEnable),
        .feedbackModulatorOrder(feedbackModulatorOrder),
        .feedbackDivideInteger(feedbackDivideInteger),
        .feedbackDivideFraction(feedbackDivideFraction),
        .converterInput(converterInput), .sysDivInteger(sysDivInteger),
        .sysDivTotal(sysDivTotal)
    );
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // Write, or read with the expected word noted
    task automatic op(input logic w, input logic [2:0] a, input logic [15:0] v);
        regWrEn = w;
        regRdEn = !w;
        regAddr = a;
        regWrData = v;
        if (!w) expQ.push_back(v);
        @(negedge ref_clk);
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(negedge ref_clk) begin
        if (regRdValid === 1'b1) chk("read", expQ.size() > 0 ? expQ.pop_front() : 16'hDEAD, regRdData);
    end
    initial begin
        #5000;
        miscompares++;
        wrap_up();
    end
    initial begin
        void'($urandom(10));
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        for (int a = 0; a < 8; a++) op(1'b0, 3'(a), rstVal[a]);
        $display("Reset values done");
        for (int a = 0; a < 8; a++) begin
            d = 16'($urandom);
            if (a == 0) d[2:0] = 3'(d % 5);
            if (a == 4) d[4:0] = 5'(d % 17);
            if (a == 5) d[4:0] = 5'(10 + d % 6);
            op(1'b1, 3'(a), d);
            op(1'b0, 3'(a), d & mask[a]);
        end
        $display("Random write readback done");
        op(1'b1, 3'h4, 16'h0010);
        op(1'b1, 3'h1, 16'h0082);
        op(1'b1, 3'h3, 16'hA5C3);
        op(1'b1, 3'h5, 16'h000F);
        op(1'b1, 3'h0, 16'h0004);
        op(1'b1, 3'h2, 16'h0055);
        regWrEn = 1'b0;
        dacDynamic = 5'h10;
        repeat (2) @(negedge ref_clk);
        chk("conv", 16'h0020, 16'(converterInput));
        chk("order", 16'h0002, 16'(feedbackModulatorOrder));
        chk("frac", 16'hA5C3, feedbackDivideFraction);
        chk("total", 16'h003C, 16'(sysDivTotal));
        chk("prediv", 16'h0004, 16'(refPredivCode));
        chk("int", 16'h0055, 16'(feedbackDivideInteger));
        chk("sysdiv", 16'h000F, 16'(sysDivInteger));
        chk("enable", 16'h0001, 16'(feedbackModulatorEnable));
        op(1'b1, 3'h1, 16'h0002);
        regWrEn = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("off frac", 16'h0000, feedbackDivideFraction);
        chk("off order", 16'h0000, 16'(feedbackModulatorOrder));
        chk("off enable", 16'h0000, 16'(feedbackModulatorEnable));
        $display("Derived outputs done");
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        for (int a = 0; a < 8; a++) op(1'b0, 3'(a), rstVal[a]);
        regRdEn = 1'b0;
        @(negedge ref_clk);
        chk("reset prediv", 16'h0001, 16'(refPredivCode));
        $display("Mid-run reset done");
        wrap_up();
    end
endmodule // pdcr_regs_tb_top
`default_nettype wire
